//--- hw/gcfg_pkg.sv
// constants of the global configuration register bank
// assumes a byte-wide register port driven by the processor interface logic
package gcfg_pkg;

  // ==========================================================================
  // register addresses
  localparam logic [8:0] ADDR_BANK_SEL  = 9'h000;
  localparam logic [8:0] ADDR_MCFG_ONE  = 9'h001;
  localparam logic [8:0] ADDR_MCFG_TWO  = 9'h002;
  localparam logic [8:0] ADDR_PLL_EN    = 9'h003;
  localparam logic [8:0] ADDR_IN_EN     = 9'h004;
  localparam logic [8:0] ADDR_OUT_EN_LO = 9'h005;
  localparam logic [8:0] ADDR_OUT_EN_HI = 9'h006;
  localparam logic [8:0] ADDR_GRP_ABC   = 9'h007;
  localparam logic [8:0] ADDR_GRP_DEF   = 9'h008;

  // ==========================================================================
  // writable bit masks, reserved bits read zero
  localparam logic [7:0] MASK_BANK_SEL  = 8'h80;
  localparam logic [7:0] MASK_MCFG_ONE  = 8'hEA;
  localparam logic [7:0] MASK_MCFG_TWO  = 8'hF7;
  localparam logic [7:0] MASK_PLL_EN    = 8'h03;
  localparam logic [7:0] MASK_IN_EN     = 8'h07;
  localparam logic [7:0] MASK_OUT_EN_LO = 8'hFF;
  localparam logic [7:0] MASK_OUT_EN_HI = 8'h03;
  localparam logic [7:0] MASK_GRP       = 8'h3F;
  localparam logic [7:0] RESET_VALUE    = 8'h00;

  // ==========================================================================
  // field positions
  localparam int BIT_BANK_SEL   = 7;
  localparam int BIT_SOFT_RST   = 7;
  localparam int BIT_HARD_RST   = 6;
  localparam int BIT_GLOBAL_STOP = 5;
  localparam int BIT_RING_OSC   = 3;
  localparam int BIT_OPEN_DRAIN = 1;
  localparam int BIT_DOUBLER    = 2;
  localparam int NUM_OUTPUTS    = 10;
  localparam int NUM_GROUPS     = 6;

  localparam logic [3:0] STOP_SRC_REG = 4'h1;

  typedef enum logic [1:0] {
    PIN_OFF     = 2'h0,
    PIN_CRYSTAL = 2'h1,
    PIN_OSC_IN  = 2'h2,
    PIN_UNUSED  = 2'h3
  } xtal_mode_t;

  typedef enum logic [1:0] {
    SRC_PLL1_INT  = 2'h0,
    SRC_PLL1_FRAC = 2'h1,
    SRC_PLL2_INT  = 2'h2,
    SRC_PLL2_FRAC = 2'h3
  } grp_src_t;

endpackage

//--- hw/gcfg_ctl_if.sv
// bundle of register bank controls passed to the output decoder
// assumes one clock domain shared by both ends
`timescale 1ns/10ps
interface gcfg_ctl_if;
  logic [1:0]  grp_src [6];
  logic [9:0]  out_en;
  logic        global_stop;
  logic [9:0]  local_stop;
  logic [3:0]  stop_src [10];
  logic        pll1_bypass;
  logic        pll2_bypass;
  logic [3:0]  pll_sel [6];
  logic [9:0]  out_stop;
  logic [9:0]  out_run;
  modport regs (output grp_src, out_en, global_stop, local_stop, stop_src,
                pll1_bypass, pll2_bypass, input pll_sel, out_stop, out_run);
  modport dec  (input grp_src, out_en, global_stop, local_stop, stop_src,
                pll1_bypass, pll2_bypass, output pll_sel, out_stop, out_run);
endinterface

//--- hw/gcfg_out_decode.sv
// combinational decode of group sources and per-output stop controls
// assumes inputs come from registers on the same clock
`timescale 1ns/10ps
module gcfg_out_decode
  import gcfg_pkg::*;
(
  gcfg_ctl_if.dec ctl
);

  // map output index to its group
  function automatic int grp_of(input int o);
    case (o)
      0, 1:    grp_of = 0;
      2:       grp_of = 1;
      3, 4:    grp_of = 2;
      5, 6:    grp_of = 3;
      7:       grp_of = 4;
      default: grp_of = 5;
    endcase
  endfunction

  // ==========================================================================
  // source select: one-hot int1, frac1, bypass1, int2/frac2/bypass2 in bit 3
  always_comb begin
    for (int g = 0; g < NUM_GROUPS; g++) begin
      case (grp_src_t'(ctl.grp_src[g]))
        SRC_PLL1_INT:  ctl.pll_sel[g] = 4'h1;
        SRC_PLL1_FRAC: ctl.pll_sel[g] = ctl.pll1_bypass ? 4'h4 : 4'h2;
        SRC_PLL2_INT:  ctl.pll_sel[g] = 4'h9;
        SRC_PLL2_FRAC: ctl.pll_sel[g] = ctl.pll2_bypass ? 4'hC : 4'hA;
        default:       ctl.pll_sel[g] = 4'h0;
      endcase
    end
  end

  // ==========================================================================
  always_comb begin
    for (int o = 0; o < NUM_OUTPUTS; o++) begin
      ctl.out_stop[o] = (ctl.stop_src[o] == STOP_SRC_REG) &&
                        (ctl.global_stop || ctl.local_stop[o]);
      ctl.out_run[o] = ctl.out_en[o] && !ctl.out_stop[o] &&
                       (ctl.pll_sel[grp_of(o)] != 4'h0);
    end
  end

endmodule // gcfg_out_decode

//--- hw/gcfg_regs.sv
// global configuration register bank of a clock synthesizer
// assumes a byte register port from the processor interface, same clock
//
// How it works
// - bank bit 0 maps registers above address 0, bank bit 1 maps memory.
// - bank select register at address 0 is always reachable.
// - rom window select overrides the bank bit.
// - soft reset clears all but interface, reset bits, address register, status.
// - during soft reset no pin sampling and no boot launch.
// - hard reset clears config and bank select, resamples pins, starts boot when soft reset bit is clear.
// - global stop ORed with per-output stop for register stop source.
// - per-output stop bit stops output when stop source is register.
// - ring oscillator disable bit powers ring oscillator down.
// - open drain mode drives serial out low only.
// - monitor reference bits choose PLL1 or PLL2 feedback per input.
// - crystal pin mode decodes off, crystal, oscillator input, unused.
// - PLL enable bits 0 and 1 enable PLL1 and PLL2.
// - input enable bits 0..2 enable inputs 1..3.
// - output enable bits gate dividers, phase and start/stop logic.
// - group source codes pick PLL integer or fractional/bypass path.
// - group fields at bits 1:0, 3:2, 5:4 of two registers.
// - bypass bit chooses fractional divider or bypass path.
`timescale 1ns/10ps
module gcfg_regs
  import gcfg_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [8:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       rom_window_select,
  input  wire logic       pll1_bypass,
  input  wire logic       pll2_bypass,
  input  wire logic [39:0] stop_source_select,
  input  wire logic [9:0] local_stop,
  input  wire logic       serial_out_data,
  input  wire logic       serial_out_active,
  output logic [7:0]      reg_rdata,
  output logic            mem_select,
  output logic            core_reset,
  output logic            pin_sample,
  output logic            boot_start,
  output logic            ring_osc_disable,
  output logic            serial_out_o,
  output logic            serial_out_oe,
  output logic [3:0]      monitor_ref,
  output logic            doubler_enable,
  output logic            crystal_drv_en,
  output logic            crystal_in_en,
  output logic            osc_in_en,
  output logic            pll1_enable,
  output logic            pll2_enable,
  output logic [2:0]      input_enable,
  output logic [9:0]      output_n_enable,
  output logic [23:0]     group_path_sel,
  output logic [9:0]      output_stop,
  output logic [9:0]      output_run
);

  // ==========================================================================
  // storage
  logic [7:0] bank_q;
  logic [7:0] mcfg_one_q;
  logic [7:0] mcfg_two_q;
  logic [7:0] pll_en_q;
  logic [7:0] in_en_q;
  logic [7:0] out_lo_q;
  logic [7:0] out_hi_q;
  logic [7:0] grp_abc_q;
  logic [7:0] grp_def_q;
  logic       soft_q;
  logic       hard_q;
  logic       hard_prev_q;
  logic       rx_s1_q;
  logic       rx_s2_q;
  logic       bypass1_s1_q;
  logic       bypass1_s2_q;
  logic       bypass2_s1_q;
  logic       bypass2_s2_q;
  logic       reg_space;
  logic       clear_cfg;
  logic [7:0] rdata_d;

  gcfg_ctl_if ctl ();

  // rom window wins over bank bit
  // bank bit picks registers or memory
  assign reg_space = !rom_window_select && !bank_q[BIT_BANK_SEL];
  // soft or hard reset clears config
  assign clear_cfg = soft_q || hard_q;

  // masked write helper
  function automatic logic [7:0] wmask(input logic [7:0] v, input logic [7:0] m);
    wmask = v & m;
  endfunction

  function automatic logic hit(input logic [8:0] a);
    hit = reg_wr && reg_space && (reg_addr == a);
  endfunction

  // ==========================================================================
  // bank select, outside the soft reset domain
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bank_q <= RESET_VALUE;
    end else if (hard_q) begin
      bank_q <= RESET_VALUE;
    // address 0 reachable in any bank
    end else if (reg_wr && reg_addr == ADDR_BANK_SEL) begin
      bank_q <= wmask(reg_wdata, MASK_BANK_SEL);
    end
  end

  // ==========================================================================
  // reset bits: soft survives both, hard clears itself after one cycle
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      soft_q <= 1'b0;
      hard_q <= 1'b0;
    end else if (hit(ADDR_MCFG_ONE)) begin
      soft_q <= reg_wdata[BIT_SOFT_RST];
      hard_q <= reg_wdata[BIT_HARD_RST];
    end else begin
      hard_q <= 1'b0;
    end
  end

  // ==========================================================================
  // configuration registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mcfg_one_q <= RESET_VALUE;
      mcfg_two_q <= RESET_VALUE;
      pll_en_q   <= RESET_VALUE;
      in_en_q    <= RESET_VALUE;
      out_lo_q   <= RESET_VALUE;
      out_hi_q   <= RESET_VALUE;
      grp_abc_q  <= RESET_VALUE;
      grp_def_q  <= RESET_VALUE;
    end else if (clear_cfg) begin
      // everything else held at reset value
      mcfg_one_q <= RESET_VALUE;
      mcfg_two_q <= RESET_VALUE;
      pll_en_q   <= RESET_VALUE;
      in_en_q    <= RESET_VALUE;
      out_lo_q   <= RESET_VALUE;
      out_hi_q   <= RESET_VALUE;
      grp_abc_q  <= RESET_VALUE;
      grp_def_q  <= RESET_VALUE;
    end else begin
      if (hit(ADDR_MCFG_ONE)) begin
        mcfg_one_q <= wmask(reg_wdata, MASK_MCFG_ONE & 8'h3F);
      end
      if (hit(ADDR_MCFG_TWO)) begin
        mcfg_two_q <= wmask(reg_wdata, MASK_MCFG_TWO);
      end
      if (hit(ADDR_PLL_EN)) begin
        pll_en_q <= wmask(reg_wdata, MASK_PLL_EN);
      end
      if (hit(ADDR_IN_EN)) begin
        in_en_q <= wmask(reg_wdata, MASK_IN_EN);
      end
      if (hit(ADDR_OUT_EN_LO)) begin
        out_lo_q <= wmask(reg_wdata, MASK_OUT_EN_LO);
      end
      if (hit(ADDR_OUT_EN_HI)) begin
        out_hi_q <= wmask(reg_wdata, MASK_OUT_EN_HI);
      end
      if (hit(ADDR_GRP_ABC)) begin
        grp_abc_q <= wmask(reg_wdata, MASK_GRP);
      end
      if (hit(ADDR_GRP_DEF)) begin
        grp_def_q <= wmask(reg_wdata, MASK_GRP);
      end
    end
  end

  // ==========================================================================
  // read mux
  always_comb begin
    rdata_d = RESET_VALUE;
    if (reg_addr == ADDR_BANK_SEL) begin
      rdata_d = bank_q;
    end else if (reg_space) begin
      case (reg_addr)
        ADDR_MCFG_ONE:  rdata_d = mcfg_one_q | {soft_q, hard_q, 6'h00};
        ADDR_MCFG_TWO:  rdata_d = mcfg_two_q;
        ADDR_PLL_EN:    rdata_d = pll_en_q;
        ADDR_IN_EN:     rdata_d = in_en_q;
        ADDR_OUT_EN_LO: rdata_d = out_lo_q;
        ADDR_OUT_EN_HI: rdata_d = out_hi_q;
        ADDR_GRP_ABC:   rdata_d = grp_abc_q;
        ADDR_GRP_DEF:   rdata_d = grp_def_q;
        default:        rdata_d = RESET_VALUE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata  <= RESET_VALUE;
      mem_select <= 1'b0;
    end else begin
      if (reg_rd) begin
        reg_rdata <= rdata_d;
      end
      mem_select <= !reg_space;
    end
  end

  // ==========================================================================
  // reset sequencing
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      hard_prev_q <= 1'b1;
      core_reset  <= 1'b1;
      pin_sample  <= 1'b0;
      boot_start  <= 1'b0;
    end else begin
      hard_prev_q <= hard_q;
      core_reset  <= clear_cfg;
      // no sampling or boot while soft reset
      // hard reset release resamples and boots
      pin_sample  <= hard_prev_q && !hard_q && !soft_q;
      boot_start  <= hard_prev_q && !hard_q && !soft_q;
    end
  end

  // ==========================================================================
  // synchronisers for signals from other logic outside this clock
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_s1_q      <= 1'b0;
      rx_s2_q      <= 1'b0;
      bypass1_s1_q <= 1'b0;
      bypass1_s2_q <= 1'b0;
      bypass2_s1_q <= 1'b0;
      bypass2_s2_q <= 1'b0;
    end else begin
      rx_s1_q      <= serial_out_data;
      rx_s2_q      <= rx_s1_q;
      bypass1_s1_q <= pll1_bypass;
      bypass1_s2_q <= bypass1_s1_q;
      bypass2_s1_q <= pll2_bypass;
      bypass2_s2_q <= bypass2_s1_q;
    end
  end

  // ==========================================================================
  // serial data pin driver
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      serial_out_o  <= 1'b0;
      serial_out_oe <= 1'b0;
    end else if (mcfg_one_q[BIT_OPEN_DRAIN]) begin
      serial_out_o  <= 1'b0;
      serial_out_oe <= serial_out_active && !rx_s2_q;
    end else begin
      serial_out_o  <= rx_s2_q;
      serial_out_oe <= serial_out_active;
    end
  end

  // ==========================================================================
  // decoder wiring
  assign ctl.grp_src[0]  = grp_abc_q[1:0];
  assign ctl.grp_src[1]  = grp_abc_q[3:2];
  assign ctl.grp_src[2]  = grp_abc_q[5:4];
  assign ctl.grp_src[3]  = grp_def_q[1:0];
  assign ctl.grp_src[4]  = grp_def_q[3:2];
  assign ctl.grp_src[5]  = grp_def_q[5:4];
  assign ctl.out_en      = {out_hi_q[1:0], out_lo_q};
  assign ctl.global_stop = mcfg_one_q[BIT_GLOBAL_STOP];
  assign ctl.local_stop  = local_stop;
  assign ctl.pll1_bypass = bypass1_s2_q;
  assign ctl.pll2_bypass = bypass2_s2_q;
  for (genvar i = 0; i < NUM_OUTPUTS; i++) begin : g_src
    assign ctl.stop_src[i] = stop_source_select[4*i +: 4];
  end

  gcfg_out_decode u_dec (
    .ctl (ctl)
  );

  // ==========================================================================
  // registered control outputs
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ring_osc_disable <= 1'b0;
      monitor_ref      <= 4'h0;
      doubler_enable   <= 1'b0;
      crystal_drv_en   <= 1'b0;
      crystal_in_en    <= 1'b0;
      osc_in_en        <= 1'b0;
      pll1_enable      <= 1'b0;
      pll2_enable      <= 1'b0;
      input_enable     <= 3'h0;
      output_n_enable  <= 10'h000;
      group_path_sel   <= 24'h000000;
      output_stop      <= 10'h000;
      output_run       <= 10'h000;
    end else begin
      ring_osc_disable <= mcfg_one_q[BIT_RING_OSC];
      monitor_ref      <= mcfg_two_q[7:4];
      doubler_enable   <= mcfg_two_q[BIT_DOUBLER];
      crystal_drv_en   <= xtal_mode_t'(mcfg_two_q[1:0]) == PIN_CRYSTAL;
      crystal_in_en    <= xtal_mode_t'(mcfg_two_q[1:0]) == PIN_CRYSTAL;
      osc_in_en        <= xtal_mode_t'(mcfg_two_q[1:0]) == PIN_OSC_IN;
      pll1_enable      <= pll_en_q[0];
      pll2_enable      <= pll_en_q[1];
      input_enable     <= in_en_q[2:0];
      output_n_enable  <= ctl.out_en;
      group_path_sel   <= {ctl.pll_sel[5], ctl.pll_sel[4], ctl.pll_sel[3],
                           ctl.pll_sel[2], ctl.pll_sel[1], ctl.pll_sel[0]};
      output_stop      <= ctl.out_stop;
      output_run       <= ctl.out_run;
    end
  end

endmodule // gcfg_regs

//--- bench/gcfg_regs_checker.sv
// concurrent checks on the ports of the global configuration register bank
// assumes one clock domain; bound into every gcfg_regs instance
`timescale 1ns/10ps
module gcfg_regs_checker
  import gcfg_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [8:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        rom_window_select,
  input wire logic [39:0] stop_source_select,
  input wire logic [9:0]  local_stop,
  input wire logic [7:0]  reg_rdata,
  input wire logic        mem_select,
  input wire logic        core_reset,
  input wire logic        pin_sample,
  input wire logic        boot_start,
  input wire logic        crystal_drv_en,
  input wire logic        crystal_in_en,
  input wire logic        osc_in_en,
  input wire logic        pll1_enable,
  input wire logic        pll2_enable,
  input wire logic [9:0]  output_stop,
  input wire logic [9:0]  output_run
);
  // ==========================================================================
  // properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_memory_reads_zero: assert property (
    reg_rd && reg_addr inside {[ADDR_MCFG_ONE:ADDR_GRP_DEF]} && mem_select
    |=> reg_rdata == 8'h00) else $error("register read while memory mapped");
  a_bank_reads_back: assert property (
    reg_wr && reg_addr == ADDR_BANK_SEL && !core_reset ##2 reg_rd && reg_addr == ADDR_BANK_SEL
    |=> reg_rdata == ($past(reg_wdata, 3) & MASK_BANK_SEL)) else $error("bank select readback");
  a_window_reads_zero: assert property (
    reg_rd && reg_addr != ADDR_BANK_SEL && rom_window_select |=> reg_rdata == 8'h00)
    else $error("read through rom window not zero");
  a_pll_write_lands: assert property (
    reg_wr && reg_addr == ADDR_PLL_EN && !mem_select && !rom_window_select && !core_reset
    |=> ##1 {pll2_enable, pll1_enable} == $past(reg_wdata[1:0], 2))
    else $error("pll enables do not follow write");
  a_reserved_pll_zero: assert property (
    reg_rd && reg_addr == ADDR_PLL_EN |=> (reg_rdata & ~MASK_PLL_EN) == 8'h00)
    else $error("reserved bits read nonzero");
  a_xtal_mode_onehot: assert property (
    crystal_drv_en == crystal_in_en && !(crystal_in_en && osc_in_en))
    else $error("crystal pin mode decode");
  a_stop_needs_source: assert property (
    output_stop[0] |-> $past(stop_source_select[3:0]) == STOP_SRC_REG)
    else $error("stop without register stop source");
  a_local_stop_acts: assert property (
    local_stop[0] && stop_source_select[3:0] == STOP_SRC_REG && !core_reset
    |-> ##[1:2] output_stop[0]) else $error("local stop ignored");
  a_run_not_stopped: assert property (
    (output_run & output_stop) == 10'h000) else $error("stopped output still running");
  a_boot_after_hard: assert property (
    boot_start |-> pin_sample && $past(core_reset)) else $error("boot start without reset");
endmodule // gcfg_regs_checker

bind gcfg_regs gcfg_regs_checker chk_u (
  .ref_clk, .reset_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .rom_window_select,
  .stop_source_select, .local_stop, .reg_rdata, .mem_select, .core_reset, .pin_sample,
  .boot_start, .crystal_drv_en, .crystal_in_en, .osc_in_en, .pll1_enable, .pll2_enable,
  .output_stop, .output_run
);

//--- bench/host_model.sv
// host processor model for the byte register port
// assumes the bank samples strobes on the rising edge of ref_clk
`timescale 1ns/10ps
module host_model
  import gcfg_pkg::*;
#(
  parameter int DOUBLER_WAIT = 20
) (
  input  wire logic       ref_clk,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [8:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  // ==========================================================================
  // bus cycles
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 9'h1FF;
    reg_wdata = 8'h5A;
  end

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    if (a == ADDR_MCFG_TWO && d[BIT_DOUBLER]) repeat (DOUBLER_WAIT) @(posedge ref_clk);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    @(posedge ref_clk);
    #1 d = reg_rdata;
  endtask
endmodule // host_model

//--- bench/tb_global_config_registers.sv
// self-checking bench for the global configuration register bank
// assumes gcfg_regs, host_model and the bound checker are compiled first
`timescale 1ns/10ps
module tb_global_config_registers
  import gcfg_pkg::*;
();
  // ==========================================================================
  // hookup
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        rom_window_select = 1'b0;
  logic        pll1_bypass = 1'b0;
  logic        pll2_bypass = 1'b0;
  logic [39:0] stop_source_select = '0;
  logic [9:0]  local_stop = '0;
  logic        serial_out_data = 1'b0;
  logic        serial_out_active = 1'b0;
  logic        reg_wr, reg_rd, mem_select, core_reset, pin_sample, boot_start;
  logic        ring_osc_disable, serial_out_o, serial_out_oe, doubler_enable;
  logic        crystal_drv_en, crystal_in_en, osc_in_en, pll1_enable, pll2_enable;
  logic [8:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [3:0]  monitor_ref;
  logic [2:0]  input_enable;
  logic [9:0]  output_n_enable, output_stop, output_run;
  logic [23:0] group_path_sel;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          boot_seen = 0;
  int          pin_seen = 0;

  always #10 ref_clk = ~ref_clk;

  gcfg_regs dut_u (
    .ref_clk, .reset_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .rom_window_select,
    .pll1_bypass, .pll2_bypass, .stop_source_select, .local_stop, .serial_out_data,
    .serial_out_active, .reg_rdata, .mem_select, .core_reset, .pin_sample, .boot_start,
    .ring_osc_disable, .serial_out_o, .serial_out_oe, .monitor_ref, .doubler_enable,
    .crystal_drv_en, .crystal_in_en, .osc_in_en, .pll1_enable, .pll2_enable,
    .input_enable, .output_n_enable, .group_path_sel, .output_stop, .output_run
  );
  host_model host_u (.ref_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);

  always @(posedge ref_clk) begin
    if (boot_start === 1'b1) boot_seen++;
    if (pin_sample === 1'b1) pin_seen++;
  end

  // ==========================================================================
  // helpers
  task automatic stop_test();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [8:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host_u.rd(a, d);
    chk(d, exp);
  endtask

  task automatic settle();
    repeat (5) @(posedge ref_clk);
    #1;
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_masks();
    logic [8:0] ad [9] = '{ADDR_BANK_SEL, ADDR_MCFG_ONE, ADDR_MCFG_TWO, ADDR_PLL_EN,
                           ADDR_IN_EN, ADDR_OUT_EN_LO, ADDR_OUT_EN_HI, ADDR_GRP_ABC,
                           ADDR_GRP_DEF};
    logic [7:0] mk [9] = '{MASK_BANK_SEL, MASK_MCFG_ONE, MASK_MCFG_TWO, MASK_PLL_EN,
                           MASK_IN_EN, MASK_OUT_EN_LO, MASK_OUT_EN_HI, MASK_GRP, MASK_GRP};
    logic [7:0] wv;
    for (int i = 0; i < 9; i++) begin
      wv = i == 0 ? 8'h7F : (i == 1 ? 8'h3F : 8'hFF);
      host_u.wr(ad[i], wv);
      rchk(ad[i], mk[i] & wv);
      host_u.wr(ad[i], 8'h00);
    end
    rchk(9'h0FF, 8'h00);
  endtask

  task automatic t_fields();
    logic [2:0] xe [4] = '{3'b000, 3'b110, 3'b001, 3'b000};
    host_u.wr(ADDR_PLL_EN, 8'h02);
    host_u.wr(ADDR_IN_EN, 8'h05);
    host_u.wr(ADDR_OUT_EN_LO, 8'h5A);
    host_u.wr(ADDR_OUT_EN_HI, 8'h02);
    host_u.wr(ADDR_MCFG_TWO, 8'hA4);
    host_u.wr(ADDR_MCFG_ONE, 8'h08);
    settle();
    chk({pll2_enable, pll1_enable}, 2'b10);
    chk(input_enable, 3'b101);
    chk(output_n_enable, 10'h25A);
    chk(monitor_ref, 4'b1010);
    chk({doubler_enable, ring_osc_disable}, 2'b11);
    for (int m = 0; m < 4; m++) begin
      host_u.wr(ADDR_MCFG_TWO, 8'(m));
      settle();
      chk({crystal_drv_en, crystal_in_en, osc_in_en}, xe[m]);
    end
  endtask

  task automatic t_groups();
    logic [3:0]  ge [8] = '{4'h1, 4'h2, 4'h9, 4'hA, 4'h1, 4'h4, 4'h9, 4'hC};
    logic [1:0]  k [6];
    logic [23:0] e;
    for (int b = 0; b < 2; b++) begin
      pll1_bypass <= 1'(b);
      pll2_bypass <= 1'(b);
      for (int c = 0; c < 4; c++) begin
        for (int g = 0; g < 6; g++) begin
          k[g] = 2'(c + g);
          e[g*4 +: 4] = ge[b*4 + k[g]];
        end
        host_u.wr(ADDR_GRP_ABC, {2'b00, k[2], k[1], k[0]});
        host_u.wr(ADDR_GRP_DEF, {2'b00, k[5], k[4], k[3]});
        settle();
        chk(group_path_sel, e);
      end
    end
  endtask

  task automatic t_stop();
    stop_source_select <= {4'h0, {9{STOP_SRC_REG}}};
    local_stop <= 10'h201;
    host_u.wr(ADDR_MCFG_ONE, 8'h00);
    settle();
    chk(output_stop, 10'h001);
    chk(output_run, 10'h25A);
    local_stop <= 10'h000;
    host_u.wr(ADDR_MCFG_ONE, 8'h20);
    settle();
    chk(output_stop, 10'h1FF);
    chk(output_run, 10'h200);
    host_u.wr(ADDR_MCFG_ONE, 8'h00);
  endtask

  task automatic t_bank();
    host_u.wr(ADDR_PLL_EN, 8'h01);
    host_u.wr(ADDR_BANK_SEL, 8'h80);
    rchk(ADDR_PLL_EN, 8'h00);
    chk(mem_select, 1'b1);
    host_u.wr(ADDR_PLL_EN, 8'h02);
    rchk(ADDR_BANK_SEL, 8'h80);
    host_u.wr(ADDR_BANK_SEL, 8'h00);
    rchk(ADDR_PLL_EN, 8'h01);
    rom_window_select <= 1'b1;
    rchk(ADDR_PLL_EN, 8'h00);
    host_u.wr(ADDR_PLL_EN, 8'h02);
    rom_window_select <= 1'b0;
    rchk(ADDR_PLL_EN, 8'h01);
  endtask

  task automatic t_drain();
    serial_out_active <= 1'b1;
    for (int od = 0; od < 2; od++) begin
      host_u.wr(ADDR_MCFG_ONE, od == 1 ? 8'h02 : 8'h00);
      for (int d = 0; d < 2; d++) begin
        serial_out_data <= 1'(d);
        settle();
        chk({serial_out_o, serial_out_oe}, od == 1 ? {1'b0, ~1'(d)} : {1'(d), 1'b1});
      end
    end
    serial_out_active <= 1'b0;
    settle();
    chk(serial_out_oe, 1'b0);
  endtask

  task automatic t_resets();
    int b0;
    host_u.wr(ADDR_PLL_EN, 8'h03);
    b0 = boot_seen + pin_seen;
    host_u.wr(ADDR_MCFG_ONE, 8'h80);
    settle();
    chk(core_reset, 1'b1);
    rchk(ADDR_PLL_EN, 8'h00);
    host_u.wr(ADDR_PLL_EN, 8'h03);
    rchk(ADDR_PLL_EN, 8'h00);
    rchk(ADDR_MCFG_ONE, 8'h80);
    host_u.wr(ADDR_MCFG_ONE, 8'hC0);
    host_u.wr(ADDR_MCFG_ONE, 8'h00);
    settle();
    chk({core_reset, boot_seen + pin_seen == b0}, 2'b01);
    host_u.wr(ADDR_PLL_EN, 8'h03);
    host_u.wr(ADDR_MCFG_ONE, 8'h40);
    for (int i = 0; i < 10 && boot_seen + pin_seen == b0; i++) @(posedge ref_clk);
    #1;
    chk(boot_seen + pin_seen == b0 + 2, 1'b1);
    if (boot_seen + pin_seen == b0) stop_test();
    settle();
    chk(core_reset, 1'b0);
    rchk(ADDR_PLL_EN, 8'h00);
    rchk(ADDR_MCFG_ONE, 8'h00);
    host_u.wr(ADDR_PLL_EN, 8'h03);
    reset_n <= 1'b0;
    settle();
    chk(core_reset, 1'b1);
    reset_n <= 1'b1;
    rchk(ADDR_PLL_EN, 8'h00);
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 9; i++) rchk(9'(i), RESET_VALUE);
    chk({core_reset, pll1_enable, output_n_enable, output_stop}, '0);
    host_u.wr(ADDR_OUT_EN_LO, 8'hFF);
    host_u.wr(ADDR_OUT_EN_HI, 8'h03);
    t_masks();
    t_fields();
    t_groups();
    t_stop();
    t_bank();
    t_drain();
    t_resets();
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    stop_test();
  end
endmodule // tb_global_config_registers
